// ---- hw/smcg_pkg.sv ----
// Purpose: Shared constants and types for the sleep clock gating block
// Assumes: One system clock, synchronous active-high reset
// Notes: Mode codes are local to this block
`default_nettype none
package smcg_pkg;
    // ==========================================================
    // Sleep modes
    typedef enum logic [2:0] {
        SMCG_IDLE,
        SMCG_PWR_DOWN,
        SMCG_PWR_SAVE,
        SMCG_ADC_NR,
        SMCG_STANDBY,
        SMCG_EXT_STANDBY,
        SMCG_DEEP_SLEEP
    } smcg_mode_t;

    // ==========================================================
    // Controller states
    typedef enum logic [1:0] {
        SMCG_ST_RUN,
        SMCG_ST_SLEEP
    } smcg_state_t;

    // ==========================================================
    // Gate vector bit positions
    localparam int SMCG_G_CPU = 0;
    localparam int SMCG_G_SRAM = 1;
    localparam int SMCG_G_TIMER = 2;
    localparam int SMCG_G_SPI = 3;
    localparam int SMCG_G_IRQ = 4;
    localparam int SMCG_G_MAIN_OSC = 5;
    localparam int SMCG_G_RC_OSC = 6;
    localparam int SMCG_G_ASYNC_TMR = 7;
    localparam int SMCG_G_ADC = 8;
    localparam int SMCG_G_WDT = 9;
    localparam int SMCG_G_SYMCNT = 10;
    localparam int SMCG_G_OSC32K = 11;
    localparam int SMCG_G_DIGITAL = 12;
    localparam int SMCG_NGATE = 13;

    localparam logic [SMCG_NGATE-1:0] SMCG_ALL_ON = 13'h1fff;
    localparam logic [SMCG_NGATE-1:0] SMCG_ALL_OFF = 13'h0000;
endpackage : smcg_pkg
`default_nettype wire

// ---- hw/smcg_top.sv ----
// Purpose: Sleep mode clock gating controller
// Assumes: Sleep request and wake inputs come from logic on clk_sys_i
// Notes: Enables are levels, one per clocked unit; high means clock runs
`timescale 1ns/1ps
`default_nettype none
module smcg_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sleep_req_i,
    input wire smcg_pkg::smcg_mode_t mode_i,
    input wire logic wake_irq_i,
    input wire logic ds_keep_wdt_i,
    input wire logic ds_keep_symcnt_i,
    input wire logic ds_keep_osc32k_i,
    output logic [smcg_pkg::SMCG_NGATE-1:0] clk_en_o,
    output logic sleeping_o,
    output smcg_pkg::smcg_mode_t mode_o
);
    // ==========================================================
    // Gate pattern per mode
    function automatic logic [smcg_pkg::SMCG_NGATE-1:0] gate_of(
        input smcg_pkg::smcg_mode_t m, input logic kw, input logic ks,
        input logic ko);
        logic [smcg_pkg::SMCG_NGATE-1:0] g;
        g = smcg_pkg::SMCG_ALL_OFF;
        case (m)
            smcg_pkg::SMCG_IDLE: begin
                g = smcg_pkg::SMCG_ALL_ON;
                g[smcg_pkg::SMCG_G_CPU] = 1'b0;
            end
            smcg_pkg::SMCG_PWR_DOWN: g = smcg_pkg::SMCG_ALL_OFF;
            smcg_pkg::SMCG_PWR_SAVE: begin
                g[smcg_pkg::SMCG_G_ASYNC_TMR] = 1'b1;
                g[smcg_pkg::SMCG_G_IRQ] = 1'b1;
            end
            smcg_pkg::SMCG_ADC_NR: begin
                g[smcg_pkg::SMCG_G_ASYNC_TMR] = 1'b1;
                g[smcg_pkg::SMCG_G_ADC] = 1'b1;
                g[smcg_pkg::SMCG_G_MAIN_OSC] = 1'b1;
            end
            smcg_pkg::SMCG_STANDBY: g[smcg_pkg::SMCG_G_RC_OSC] = 1'b1;
            smcg_pkg::SMCG_EXT_STANDBY: begin
                g[smcg_pkg::SMCG_G_RC_OSC] = 1'b1;
                g[smcg_pkg::SMCG_G_ASYNC_TMR] = 1'b1;
            end
            smcg_pkg::SMCG_DEEP_SLEEP: begin
                g[smcg_pkg::SMCG_G_WDT] = kw;
                g[smcg_pkg::SMCG_G_SYMCNT] = ks;
                g[smcg_pkg::SMCG_G_OSC32K] = ko;
            end
            default: g = smcg_pkg::SMCG_ALL_ON;
        endcase
        return g;
    endfunction : gate_of

    // ==========================================================
    // Sleep state machine
    smcg_pkg::smcg_state_t state_r, state_nxt;
    smcg_pkg::smcg_mode_t mode_r, mode_nxt;
    logic [smcg_pkg::SMCG_NGATE-1:0] en_r, en_nxt;

    // Next state; wake beats a same-cycle sleep request
    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        en_nxt = en_r;
        case (state_r)
            smcg_pkg::SMCG_ST_RUN: begin
                en_nxt = smcg_pkg::SMCG_ALL_ON;
                if (sleep_req_i && !wake_irq_i) begin
                    state_nxt = smcg_pkg::SMCG_ST_SLEEP;
                    mode_nxt = mode_i;
                    en_nxt = gate_of(mode_i, ds_keep_wdt_i,
                        ds_keep_symcnt_i, ds_keep_osc32k_i);
                end
            end
            smcg_pkg::SMCG_ST_SLEEP: begin
                if (wake_irq_i) begin
                    state_nxt = smcg_pkg::SMCG_ST_RUN;
                    en_nxt = smcg_pkg::SMCG_ALL_ON;
                end
            end
            default: begin
                state_nxt = smcg_pkg::SMCG_ST_RUN;
                en_nxt = smcg_pkg::SMCG_ALL_ON;
            end
        endcase
    end

    // Registers; reset counts as a wake
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= smcg_pkg::SMCG_ST_RUN;
            mode_r <= smcg_pkg::SMCG_IDLE;
            en_r <= smcg_pkg::SMCG_ALL_ON;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            en_r <= en_nxt;
        end
    end

    // Outputs straight off the registers, so enables never glitch
    assign clk_en_o = en_r;
    assign sleeping_o = (state_r == smcg_pkg::SMCG_ST_SLEEP);
    assign mode_o = mode_r;

    // ==========================================================
    // Checks
    // All checks run on the system clock and rest during reset
    default clocking chk_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Any accepted sleep request
    sequence entry_s;
        state_r == smcg_pkg::SMCG_ST_RUN && sleep_req_i && !wake_irq_i;
    endsequence

    // Accepted sleep request for one given mode
    sequence enter_s(smcg_pkg::smcg_mode_t m);
        state_r == smcg_pkg::SMCG_ST_RUN && sleep_req_i && !wake_irq_i
            && mode_i == m;
    endsequence

    // Every clock enable low
    sequence all_off_s;
        clk_en_o == smcg_pkg::SMCG_ALL_OFF;
    endsequence

    // Asleep, no wake pending
    sequence calm_s;
        sleeping_o && !wake_irq_i;
    endsequence

    // Wake taken while asleep
    sequence wake_s;
        sleeping_o && wake_irq_i;
    endsequence

    mode_latch_a: assert property (
        entry_s |=>
        sleeping_o && mode_o == $past(mode_i))
        else $error("sleep entry did not latch the mode");

    sleep_hold_a: assert property (
        calm_s |=>
        sleeping_o && $stable(clk_en_o) && $stable(mode_o))
        else $error("gating changed while asleep");

    idle_cpu_off_a: assert property (
        enter_s(smcg_pkg::SMCG_IDLE) |=>
        !clk_en_o[smcg_pkg::SMCG_G_CPU]
        && clk_en_o[smcg_pkg::SMCG_G_SRAM]
        && clk_en_o[smcg_pkg::SMCG_G_TIMER]
        && clk_en_o[smcg_pkg::SMCG_G_SPI]
        && clk_en_o[smcg_pkg::SMCG_G_IRQ])
        else $error("idle gating wrong");

    // dark the cycle after entry and the next unless woken; a wake may follow entry at once
    pwr_down_off_a: assert property (
        enter_s(smcg_pkg::SMCG_PWR_DOWN) |=>
        all_off_s ##1
        ($past(wake_irq_i) || clk_en_o == smcg_pkg::SMCG_ALL_OFF))
        else $error("power-down gating wrong");

    pwr_save_a: assert property (
        enter_s(smcg_pkg::SMCG_PWR_SAVE) |=>
        clk_en_o[smcg_pkg::SMCG_G_ASYNC_TMR]
        && !clk_en_o[smcg_pkg::SMCG_G_CPU])
        else $error("power-save gating wrong");

    adc_nr_a: assert property (
        enter_s(smcg_pkg::SMCG_ADC_NR) |=>
        clk_en_o[smcg_pkg::SMCG_G_ADC]
        && clk_en_o[smcg_pkg::SMCG_G_ASYNC_TMR]
        && !clk_en_o[smcg_pkg::SMCG_G_CPU]
        && !clk_en_o[smcg_pkg::SMCG_G_TIMER]
        && !clk_en_o[smcg_pkg::SMCG_G_SPI])
        else $error("adc noise gating wrong");

    standby_rc_a: assert property (
        enter_s(smcg_pkg::SMCG_STANDBY) |=>
        $onehot(clk_en_o) && clk_en_o[smcg_pkg::SMCG_G_RC_OSC])
        else $error("standby gating wrong");

    ext_standby_a: assert property (
        enter_s(smcg_pkg::SMCG_EXT_STANDBY) |=>
        clk_en_o[smcg_pkg::SMCG_G_RC_OSC]
        && clk_en_o[smcg_pkg::SMCG_G_ASYNC_TMR]
        && !clk_en_o[smcg_pkg::SMCG_G_TIMER])
        else $error("extended standby gating wrong");

    deep_keep_a: assert property (
        enter_s(smcg_pkg::SMCG_DEEP_SLEEP) |=>
        clk_en_o[smcg_pkg::SMCG_G_WDT] == $past(ds_keep_wdt_i)
        && clk_en_o[smcg_pkg::SMCG_G_SYMCNT] == $past(ds_keep_symcnt_i)
        && clk_en_o[smcg_pkg::SMCG_G_OSC32K] == $past(ds_keep_osc32k_i)
        && !clk_en_o[smcg_pkg::SMCG_G_DIGITAL])
        else $error("deep sleep gating wrong");

    wake_restore_a: assert property (
        wake_s |=>
        clk_en_o == smcg_pkg::SMCG_ALL_ON && !sleeping_o)
        else $error("wake did not restore clocks");

    wake_wins_a: assert property (
        state_r == smcg_pkg::SMCG_ST_RUN && sleep_req_i && wake_irq_i |=>
        !sleeping_o && clk_en_o == smcg_pkg::SMCG_ALL_ON)
        else $error("sleep entered despite a wake");

    run_all_on_a: assert property (
        !sleeping_o |-> clk_en_o == smcg_pkg::SMCG_ALL_ON)
        else $error("clock gated while running");

    reset_state_a: assert property (
        $past(rst_i) |->
        clk_en_o == smcg_pkg::SMCG_ALL_ON && !sleeping_o
        && mode_o == smcg_pkg::SMCG_IDLE)
        else $error("reset did not restore clocks");
endmodule : smcg_top
`default_nettype wire

// ---- tb/sleep_mode_clock_gating_tb.sv ----
// Purpose: Self-checking bench for the sleep clock gating controller
// Assumes: Gate map and mode codes as fixed in smcg_pkg
// Notes: Idle only checks the bits that the idle mode pins down
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_clock_gating_tb;
    typedef struct packed {
        logic [12:0] en;
        logic [12:0] mask;
        logic slp;
        logic [2:0] md;
    } smcg_note_t;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic sleep_req_i = 1'b0;
    logic wake_irq_i = 1'b0;
    logic [2:0] keep = 3'h0;
    smcg_pkg::smcg_mode_t mode_i = smcg_pkg::SMCG_IDLE;
    logic [12:0] clk_en_o;
    logic sleeping_o;
    smcg_pkg::smcg_mode_t mode_o;
    int mismatches = 0;
    int n_tests = 0;
    smcg_note_t notes[$];
    smcg_note_t n;
    logic [2:0] kp;
    smcg_pkg::smcg_mode_t m;

    smcg_top i_smcg_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .sleep_req_i(sleep_req_i), .mode_i(mode_i), .wake_irq_i(wake_irq_i),
        .ds_keep_wdt_i(keep[0]), .ds_keep_symcnt_i(keep[1]),
        .ds_keep_osc32k_i(keep[2]), .clk_en_o(clk_en_o),
        .sleeping_o(sleeping_o), .mode_o(mode_o));

    // ==========================================================
    // Clock, 25 ns period
    always #12.5 clk_sys_i = ~clk_sys_i;

    // Running gates per mode; idle sets only the SRAM, timer, SPI and IRQ bits
    function automatic logic [12:0] gates(smcg_pkg::smcg_mode_t md,
                                          logic [2:0] k);
        case (md)
            smcg_pkg::SMCG_IDLE: return 13'h001e;
            smcg_pkg::SMCG_PWR_DOWN: return 13'h0000;
            smcg_pkg::SMCG_PWR_SAVE: return 13'h0090;
            smcg_pkg::SMCG_ADC_NR: return 13'h01a0;
            smcg_pkg::SMCG_STANDBY: return 13'h0040;
            smcg_pkg::SMCG_EXT_STANDBY: return 13'h00c0;
            default: return {1'b0, k, 9'h000};
        endcase
    endfunction : gates

    task automatic check(string what, logic [12:0] seen, logic [12:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    // Drive on falling edge, note the result due after next rise
    task automatic step(logic rq, logic wk, logic rs,
                        smcg_pkg::smcg_mode_t md, logic [2:0] k,
                        logic [12:0] en, logic [12:0] mk, logic slp,
                        smcg_pkg::smcg_mode_t mo);
        @(negedge clk_sys_i);
        sleep_req_i = rq;
        wake_irq_i = wk;
        rst_i = rs;
        mode_i = md;
        keep = k;
        notes.push_back(smcg_note_t'{en, mk, slp, mo});
    endtask : step

    // ==========================================================
    // Monitor: one note per cycle, compared once outputs settle
    always @(posedge clk_sys_i) begin
        #1;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            check("clk_en", clk_en_o & n.mask, n.en & n.mask);
            check("sleeping", {12'h000, sleeping_o}, {12'h000, n.slp});
            check("mode", {10'h000, mode_o}, {10'h000, n.md});
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Hang guard, far beyond the roughly 42 cycle sequence
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        mismatches++;
        $display("watchdog expired");
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h00d5_fd0e));
        repeat (8) @(posedge clk_sys_i);
        for (int i = 0; i < 7; i++) begin
            m = smcg_pkg::smcg_mode_t'(i);
            kp = 3'($urandom());
            step(1, 0, 0, m, kp, gates(m, kp),
                 (i == 0) ? 13'h001f : 13'h1fff,
                 1, m);
            // Changes while asleep must be ignored
            step(1, 0, 0, smcg_pkg::smcg_mode_t'($urandom() % 7), ~kp,
                 gates(m, kp), (i == 0) ? 13'h001f : 13'h1fff, 1, m);
            step(0, 1, 0, m, kp, 13'h1fff, 13'h1fff, 0, m);
            // Wake beats a same-cycle request
            step(1, 1, 0, m, kp, 13'h1fff, 13'h1fff, 0, m);
            $display("test mode %0d done", i);
        end
        // Reset in mid-sleep restores all clocks
        step(1, 0, 0, smcg_pkg::SMCG_PWR_DOWN, 3'h0, 13'h0000, 13'h1fff, 1,
             smcg_pkg::SMCG_PWR_DOWN);
        step(1, 0, 1, smcg_pkg::SMCG_STANDBY, 3'h7, 13'h1fff, 13'h1fff, 0,
             smcg_pkg::SMCG_IDLE);
        // First request right after release, woken on the next edge
        step(1, 0, 0, smcg_pkg::SMCG_PWR_DOWN, 3'h7, 13'h0000, 13'h1fff, 1,
             smcg_pkg::SMCG_PWR_DOWN);
        step(0, 1, 0, smcg_pkg::SMCG_PWR_DOWN, 3'h7, 13'h1fff, 13'h1fff, 0,
             smcg_pkg::SMCG_PWR_DOWN);
        $display("test reset in sleep done");
        repeat (3) @(posedge clk_sys_i);
        wrap_up();
    end
endmodule : sleep_mode_clock_gating_tb
`default_nettype wire
